/* File: rtl/spc_ctrl.sv */
// serial port control: apb registers, spi master/slave and i2c master/slave engine
`timescale 1ns/100ps
`include "spc_cfg.svh"
module spc_ctrl (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_timer_two_period_match,
  input wire logic i_spi_clock_pin,
  input wire logic i_spi_data_in_pin,
  input wire logic i_spi_select_pin_n,
  input wire logic i_scl_in,
  input wire logic i_sda_in,
  output logic o_spi_clock_pin,
  output logic o_spi_clock_oe,
  output logic o_spi_data_out_pin,
  output logic o_spi_data_out_oe,
  output logic o_scl_out,
  output logic o_scl_oe,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_spi_pins_owned,
  output logic o_select_pin_owned,
  output logic o_i2c_pins_owned,
  output logic o_port_event
);
  import spc_pkg::*;

  spc_state_s q_reg;
  spc_state_s d_next;

  // ==========================================
  // mode decode
  function automatic logic is_spi_mst(input logic [3:0] m);
    is_spi_mst = (m <= `SPC_M_SPITMR) || (m == `SPC_M_SPIDIV);
  endfunction

  function automatic logic is_spi_sl(input logic [3:0] m);
    is_spi_sl = (m == `SPC_M_SPISL) || (m == `SPC_M_SPISLNS);
  endfunction

  function automatic logic is_i2c_mst(input logic [3:0] m);
    is_i2c_mst = (m == `SPC_M_I2CMST) || (m == `SPC_M_I2CFW);
  endfunction

  // 0110, 0111, 1110, 1111; reserved codes decode to nothing
  function automatic logic is_i2c_sl(input logic [3:0] m);
    is_i2c_sl = (m[2:1] == 2'h3);
  endfunction

  // spi ticks are half periods, i2c ticks quarter periods
  function automatic logic [8:0] brg_reload(input logic [3:0] m, input logic [7:0] dv);
    case (m)
      `SPC_M_SPI4: brg_reload = 9'h1;
      `SPC_M_SPI16: brg_reload = {`SPC_DIV16, 1'b1};
      `SPC_M_SPI64: brg_reload = {`SPC_DIV64, 1'b1};
      `SPC_M_SPIDIV: brg_reload = {dv, 1'b1};
      default: brg_reload = {1'b0, dv};
    endcase
  endfunction

  logic wr;
  logic rd;
  logic tick;
  logic rx_done;
  logic i2c_mode;
  logic mst_busy;
  logic scl_rise;
  logic scl_fall;
  logic sck_trail;

  assign wr = i_psel && i_penable && i_pwrite;
  assign rd = i_psel && i_penable && !i_pwrite;
  assign i2c_mode = is_i2c_mst(q_reg.mode) || is_i2c_sl(q_reg.mode);
  // idle means no step running and no request pending
  assign mst_busy = (q_reg.st != ST_IDLE) || q_reg.ack_sequence_request || q_reg.master_receive_request || q_reg.stop_request || q_reg.restart_request || q_reg.start_request_or_stretch_enable;
  assign scl_rise = !q_reg.prev_scl && i_scl_in;
  assign scl_fall = q_reg.prev_scl && !i_scl_in;
  // trailing edge: clock returns to its idle level
  assign sck_trail = (q_reg.prev_sck != q_reg.clock_polarity_release) && (i_spi_clock_pin == q_reg.clock_polarity_release);

  // ==========================================
  // apb slave: zero wait, error on unmapped address
  assign o_pready = 1'b1;
  always_comb begin
    o_prdata = 32'h0;
    o_pslverr = 1'b0;
    case (i_paddr)
      `SPC_A_CON1: o_prdata[7:0] = {q_reg.write_collision_flag, q_reg.ov, q_reg.en, q_reg.clock_polarity_release, q_reg.mode};
      `SPC_A_CON2: o_prdata[7:0] = {q_reg.general_call_enable, q_reg.ack_received_status, q_reg.ack_value_to_send, q_reg.ack_sequence_request,
                                    q_reg.master_receive_request, q_reg.stop_request, q_reg.restart_request, q_reg.start_request_or_stretch_enable};
      `SPC_A_CON3: o_prdata[7:0] = {q_reg.ack_ph, q_reg.pcie, q_reg.start_irq_enable, q_reg.buffer_overwrite_enable, q_reg.con3_low};
      `SPC_A_BUF: o_prdata[7:0] = q_reg.buf_d;
      `SPC_A_DIV: o_prdata[7:0] = q_reg.div;
      `SPC_A_STAT: o_prdata[1:0] = {q_reg.st != ST_IDLE, q_reg.bf};
      default: o_pslverr = i_psel && i_penable;
    endcase
  end

  // ==========================================
  // next state: software first, hardware after so a hardware update beats a software write
  always_comb begin
    d_next = q_reg;
    tick = 1'b0;
    rx_done = 1'b0;
    d_next.evt = 1'b0;
    d_next.prev_scl = i_scl_in;
    d_next.prev_sda = i_sda_in;
    d_next.prev_sck = i_spi_clock_pin;
    // divider runs only while a step is active
    if (q_reg.st == ST_IDLE) begin
      d_next.brg = brg_reload(q_reg.mode, q_reg.div);
    end else if (q_reg.mode == `SPC_M_SPITMR) begin
      tick = i_timer_two_period_match;
    end else if (q_reg.brg == 9'h0) begin
      tick = 1'b1;
      d_next.brg = brg_reload(q_reg.mode, q_reg.div);
    end else begin
      d_next.brg = q_reg.brg - 9'h1;
    end
    if (wr) begin
      case (i_paddr)
        `SPC_A_CON1: begin
          d_next.write_collision_flag = q_reg.write_collision_flag && i_pwdata[`SPC_B7];
          d_next.ov = q_reg.ov && i_pwdata[`SPC_B6];
          d_next.en = i_pwdata[`SPC_B5];
          d_next.clock_polarity_release = i_pwdata[`SPC_B4];
          d_next.mode = i_pwdata[3:0];
        end
        `SPC_A_CON2: begin
          d_next.general_call_enable = i_pwdata[`SPC_B7];
          d_next.ack_value_to_send = i_pwdata[`SPC_B5];
          if (!(is_i2c_mst(q_reg.mode) && mst_busy)) begin
            d_next.ack_sequence_request = i_pwdata[`SPC_B4];
            d_next.master_receive_request = i_pwdata[`SPC_B3];
            d_next.stop_request = i_pwdata[`SPC_B2];
            d_next.restart_request = i_pwdata[`SPC_B1];
            d_next.start_request_or_stretch_enable = i_pwdata[`SPC_B0];
          end
        end
        `SPC_A_CON3: begin
          d_next.pcie = i_pwdata[`SPC_B6];
          d_next.start_irq_enable = i_pwdata[`SPC_B5];
          d_next.buffer_overwrite_enable = i_pwdata[`SPC_B4];
          d_next.con3_low = i_pwdata[3:0];
        end
        `SPC_A_DIV: d_next.div = i_pwdata[7:0];
        `SPC_A_BUF: begin
          if ((is_spi_mst(q_reg.mode) || is_i2c_mst(q_reg.mode)) && mst_busy) begin
            d_next.write_collision_flag = 1'b1;
          end else if ((is_spi_sl(q_reg.mode) && q_reg.bitn != 4'h0) ||
                       (is_i2c_sl(q_reg.mode) && q_reg.scnt != 4'h0 && q_reg.scnt != `SPC_SCNT_IDLE)) begin
            d_next.write_collision_flag = 1'b1;
          end else begin
            d_next.sr = i_pwdata[7:0];
            d_next.ph = 2'h0;
            d_next.bitn = 4'h0;
            if (q_reg.en && is_spi_mst(q_reg.mode)) begin
              d_next.st = ST_SPI;
            end else if (q_reg.en && q_reg.mode == `SPC_M_I2CMST) begin
              d_next.st = ST_BYTE;
              d_next.rx = 1'b0;
              d_next.bf = 1'b1; // transmit in progress
            end
          end
        end
        default: ;
      endcase
    end
    if (rd && i_paddr == `SPC_A_BUF) begin
      d_next.bf = 1'b0;
    end
    // master sequencer, an i2c step of four quarter ticks, an spi bit of two half ticks
    case (q_reg.st)
      ST_IDLE: begin
        d_next.ph = 2'h0;
        if (q_reg.en && q_reg.mode == `SPC_M_I2CMST) begin // firmware master runs no steps
          d_next.bitn = 4'h0;
          if (q_reg.start_request_or_stretch_enable) begin
            d_next.st = ST_START;
          end else if (q_reg.restart_request) begin
            d_next.st = ST_RSTART;
          end else if (q_reg.stop_request) begin
            d_next.st = ST_STOP;
          end else if (q_reg.master_receive_request) begin
            d_next.st = ST_BYTE;
            d_next.rx = 1'b1;
          end else if (q_reg.ack_sequence_request) begin
            d_next.st = ST_ACK;
          end
        end
      end
      ST_SPI: begin
        if (tick) begin
          d_next.ph = q_reg.ph + 2'h1;
          if (q_reg.ph != 2'h0) begin
            d_next.ph = 2'h0;
            d_next.sr = {q_reg.sr[6:0], i_spi_data_in_pin};
            d_next.bitn = q_reg.bitn + 4'h1;
            if (q_reg.bitn == `SPC_BIT_LAST) begin
              d_next.st = ST_IDLE;
              d_next.bitn = 4'h0;
              rx_done = 1'b1;
            end
          end
        end
      end
      default: begin
        if (tick) begin
          d_next.ph = q_reg.ph + 2'h1;
          if (q_reg.st == ST_BYTE && q_reg.ph == `SPC_PH_SAMPLE) begin
            if (q_reg.bitn == `SPC_BIT_ACK) begin
              d_next.ack_received_status = i_sda_in;
            end else begin
              d_next.sr = {q_reg.sr[6:0], i_sda_in};
            end
          end
          if (q_reg.ph == `SPC_PH_LAST) begin
            d_next.st = ST_IDLE;
            d_next.bitn = q_reg.bitn + 4'h1;
            case (q_reg.st)
              ST_START: d_next.start_request_or_stretch_enable = 1'b0;
              ST_RSTART: d_next.restart_request = 1'b0;
              ST_STOP: d_next.stop_request = 1'b0;
              ST_ACK: d_next.ack_sequence_request = 1'b0;
              default: begin
                if (q_reg.rx && q_reg.bitn == `SPC_BIT_LAST) begin
                  d_next.master_receive_request = 1'b0;
                  rx_done = 1'b1;
                end else if (!q_reg.rx && q_reg.bitn == `SPC_BIT_ACK) begin
                  d_next.bf = 1'b0;
                end else begin
                  d_next.st = ST_BYTE;
                end
              end
            endcase
          end
        end
      end
    endcase
    // spi slave shifts on the trailing edge while selected, or on every trailing edge in the no-select code
    if (q_reg.en && is_spi_sl(q_reg.mode) && sck_trail &&
        (q_reg.mode == `SPC_M_SPISLNS || !i_spi_select_pin_n)) begin
      d_next.sr = {q_reg.sr[6:0], i_spi_data_in_pin};
      d_next.bitn = q_reg.bitn + 4'h1;
      if (q_reg.bitn == `SPC_BIT_LAST) begin
        d_next.bitn = 4'h0;
        rx_done = 1'b1;
      end
    end
    // i2c bus monitor: conditions, bit count, ack phase, slave receive
    if (q_reg.en && i2c_mode) begin
      if (q_reg.prev_scl && i_scl_in && q_reg.prev_sda != i_sda_in) begin
        // the condition's own scl fall wraps this to zero, it is no data clock
        d_next.scnt = `SPC_SCNT_IDLE;
        d_next.addr_byte = !i_sda_in;
        d_next.ack_ph = 1'b0;
        if (i_sda_in) begin
          d_next.evt = q_reg.pcie || (is_i2c_sl(q_reg.mode) && q_reg.mode[3]);
        end else begin
          d_next.evt = q_reg.start_irq_enable || (is_i2c_sl(q_reg.mode) && q_reg.mode[3]);
        end
      end else if (scl_rise) begin
        if (q_reg.scnt == `SPC_BIT_ACK) begin
          d_next.ack_ph = 1'b0;
        end else if (is_i2c_sl(q_reg.mode)) begin
          d_next.sr = {q_reg.sr[6:0], i_sda_in};
        end
      end else if (scl_fall) begin
        d_next.scnt = (q_reg.scnt == `SPC_BIT_ACK) ? 4'h0 : q_reg.scnt + 4'h1;
        if (q_reg.scnt == `SPC_BIT_LAST) begin
          d_next.ack_ph = 1'b1;
          if (is_i2c_sl(q_reg.mode)) begin
            d_next.addr_byte = 1'b0;
            rx_done = 1'b1;
            if (q_reg.addr_byte && q_reg.general_call_enable && q_reg.sr == `SPC_GC_ADDR) begin
              d_next.evt = 1'b1;
            end
            if (q_reg.start_request_or_stretch_enable) begin
              d_next.clock_polarity_release = 1'b0;
            end
          end
        end
      end
    end
    // completed byte into the buffer
    if (rx_done) begin
      if (is_spi_mst(q_reg.mode) || is_i2c_mst(q_reg.mode)) begin
        d_next.buf_d = d_next.sr; // master never overflows
        d_next.bf = 1'b1;
      end else begin
        if (!q_reg.bf || q_reg.buffer_overwrite_enable) begin
          d_next.buf_d = d_next.sr;
        end
        d_next.ov = q_reg.ov || q_reg.bf;
        d_next.bf = 1'b1;
      end
    end
    // open-drain pull-downs per step and quarter
    case (d_next.st)
      ST_START: begin
        d_next.sda_low = d_next.ph >= `SPC_PH_SAMPLE;
        d_next.scl_low = d_next.ph == `SPC_PH_LAST;
      end
      ST_RSTART: begin
        d_next.sda_low = d_next.ph >= `SPC_PH_SAMPLE;
        d_next.scl_low = d_next.ph == 2'h0 || d_next.ph == `SPC_PH_LAST;
      end
      ST_STOP: begin
        d_next.sda_low = d_next.ph != `SPC_PH_LAST;
        d_next.scl_low = d_next.ph == 2'h0;
      end
      ST_BYTE: begin
        d_next.sda_low = !d_next.rx && d_next.bitn != `SPC_BIT_ACK && !d_next.sr[7];
        d_next.scl_low = d_next.ph == 2'h0 || d_next.ph == `SPC_PH_LAST;
      end
      ST_ACK: begin
        d_next.sda_low = !q_reg.ack_value_to_send;
        d_next.scl_low = d_next.ph == 2'h0 || d_next.ph == `SPC_PH_LAST;
      end
      default: ;
    endcase
    if (!q_reg.en) begin
      d_next.st = ST_IDLE;
      d_next.scl_low = 1'b0;
      d_next.sda_low = 1'b0;
      d_next.scnt = 4'h0;
    end
    // spi clock after the enable override, so a dropped transfer idles at once
    d_next.sck_o = d_next.clock_polarity_release ^ (d_next.st == ST_SPI && d_next.ph == 2'h0);
  end

  // ==========================================
  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= d_next;
    end
  end

  // ==========================================
  // pins: a cleared enable gives every pin back to general i/o
  assign o_spi_pins_owned = q_reg.en && (is_spi_mst(q_reg.mode) || is_spi_sl(q_reg.mode));
  assign o_select_pin_owned = q_reg.en && q_reg.mode == `SPC_M_SPISL;
  assign o_i2c_pins_owned = q_reg.en && i2c_mode;
  assign o_spi_clock_pin = q_reg.sck_o;
  assign o_spi_clock_oe = q_reg.en && is_spi_mst(q_reg.mode);
  assign o_spi_data_out_pin = q_reg.sr[7];
  assign o_spi_data_out_oe = o_spi_pins_owned && (is_spi_mst(q_reg.mode) || !i_spi_select_pin_n ||
                             q_reg.mode == `SPC_M_SPISLNS);
  assign o_scl_out = 1'b0;
  assign o_sda_out = 1'b0;
  // slave hold on a cleared release bit; the bit means nothing to the master
  assign o_scl_oe = o_i2c_pins_owned && (q_reg.scl_low || (is_i2c_sl(q_reg.mode) && !q_reg.clock_polarity_release));
  assign o_sda_oe = o_i2c_pins_owned && q_reg.sda_low;
  assign o_port_event = q_reg.evt;

  // ==========================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_mst_write_collision_flag;
    wr && i_paddr == `SPC_A_BUF && (is_spi_mst(q_reg.mode) || is_i2c_mst(q_reg.mode)) && mst_busy |=> q_reg.write_collision_flag;
  endproperty
  a_mst_write_collision_flag: assert property (p_mst_write_collision_flag) else $error("busy master write left no collision");

  property p_sl_write_collision_flag;
    wr && i_paddr == `SPC_A_BUF && is_spi_sl(q_reg.mode) && q_reg.bitn != 4'h0 |=> q_reg.write_collision_flag;
  endproperty
  a_sl_write_collision_flag: assert property (p_sl_write_collision_flag) else $error("slave mid-shift write left no collision");

  property p_ovf;
    rx_done && is_spi_sl(q_reg.mode) && q_reg.bf && !q_reg.buffer_overwrite_enable |=> q_reg.ov && $stable(q_reg.buf_d);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged or buffer changed");

  property p_no_ov_mst;
    (is_spi_mst(q_reg.mode) || is_i2c_mst(q_reg.mode)) && !q_reg.ov && !(wr && i_paddr == `SPC_A_CON1) |=> !q_reg.ov;
  endproperty
  a_no_ov_mst: assert property (p_no_ov_mst) else $error("overflow set in master mode");

  property p_idle_clk;
    is_spi_mst(q_reg.mode) && q_reg.st == ST_IDLE ##1 q_reg.st == ST_IDLE |-> o_spi_clock_pin == q_reg.clock_polarity_release;
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("spi idle clock level wrong");

  property p_busy_ignore;
    wr && i_paddr == `SPC_A_CON2 && is_i2c_mst(q_reg.mode) && q_reg.st != ST_IDLE && !q_reg.stop_request |=> !q_reg.stop_request;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("request accepted while busy");

  sequence s_start_req;
    $rose(q_reg.start_request_or_stretch_enable) && q_reg.mode == `SPC_M_I2CMST && q_reg.en && q_reg.div < 8'h10;
  endsequence
  sequence s_start_done;
    ##[1:200] !q_reg.start_request_or_stretch_enable;
  endsequence
  property p_start_clear;
    s_start_req |-> s_start_done;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start request never cleared");

  sequence s_ack_run;
    q_reg.st == ST_ACK && q_reg.ph == 2'h1;
  endsequence
  property p_ack_drive;
    s_ack_run |=> o_sda_oe == !q_reg.ack_value_to_send;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack cycle drives wrong value");

  property p_ack_phase;
    $rose(q_reg.ack_ph) |-> $past(scl_fall) && $past(q_reg.scnt) == `SPC_BIT_LAST;
  endproperty
  a_ack_phase: assert property (p_ack_phase) else $error("ack phase set off the eighth fall");

  property p_stretch;
    q_reg.en && is_i2c_sl(q_reg.mode) && !q_reg.clock_polarity_release |-> o_scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("slave clock not held");
endmodule

/* File: inc/spc_cfg.svh */
// register map, field positions, mode codes and step counts of the serial port control block
// Function
// - master buffer write while busy flags collision
// - slave buffer write mid-shift flags collision
// - slave byte into full buffer: overflow, discarded
// - overflow never set in master modes
// - enable hands spi pins to port
// - enable hands sda and scl to port
// - spi idle clock level follows polarity bit
// - i2c slave: polarity bit clear holds scl
// - spi master clock rate per mode code
// - spi slave with or without select
// - i2c slave codes, 7/10 bit, irq variants
// - i2c master scl from divider
// - firmware master code, reserved codes idle
// - general call address raises event when enabled
// - ack status reads one on no-ack
// - ack sequence sends ack value, self clears
// - start, restart, stop requests self clear
// - slave stretch enable clears release bit
// - busy master ignores requests and buffer writes
// - ack phase flag: eighth fall to ninth rise
// - start and stop events gated by enables, always raised in the i2c slave irq codes
// - overwrite enable replaces buffer anyway
// - buffer full set on receive, cleared on read
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
// ==========================================
// register byte addresses
`define SPC_A_CON1 8'h00
`define SPC_A_CON2 8'h04
`define SPC_A_CON3 8'h08
`define SPC_A_BUF 8'h0c
`define SPC_A_DIV 8'h10
`define SPC_A_STAT 8'h14
`define SPC_RST8 8'h00
// ==========================================
// field positions
`define SPC_B7 7
`define SPC_B6 6
`define SPC_B5 5
`define SPC_B4 4
`define SPC_B3 3
`define SPC_B2 2
`define SPC_B1 1
`define SPC_B0 0
// ==========================================
// mode codes
`define SPC_M_SPI4 4'h0
`define SPC_M_SPI16 4'h1
`define SPC_M_SPI64 4'h2
`define SPC_M_SPITMR 4'h3
`define SPC_M_SPISL 4'h4
`define SPC_M_SPISLNS 4'h5
`define SPC_M_I2CMST 4'h8
`define SPC_M_SPIDIV 4'ha
`define SPC_M_I2CFW 4'hb
// ==========================================
// step and bit counts
`define SPC_GC_ADDR 8'h00
`define SPC_DIV16 8'h03
`define SPC_DIV64 8'h0f
`define SPC_PH_SAMPLE 2'h2
`define SPC_PH_LAST 2'h3
`define SPC_BIT_LAST 4'h7
`define SPC_BIT_ACK 4'h8
`define SPC_SCNT_IDLE 4'hf
`endif

/* File: inc/spc_pkg.sv */
// types of the serial port control block
package spc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_SPI, ST_START, ST_RSTART, ST_STOP, ST_BYTE, ST_ACK} spc_state_e;
  typedef struct packed {
    logic write_collision_flag; logic ov; logic en; logic clock_polarity_release; logic [3:0] mode;
    logic general_call_enable; logic ack_received_status; logic ack_value_to_send; logic ack_sequence_request; logic master_receive_request; logic stop_request; logic restart_request; logic start_request_or_stretch_enable;
    logic ack_ph; logic pcie; logic start_irq_enable; logic buffer_overwrite_enable; logic [3:0] con3_low;
    logic [7:0] buf_d; logic [7:0] sr; logic [7:0] div; logic bf;
    spc_state_e st; logic [1:0] ph; logic [3:0] bitn; logic [8:0] brg; logic rx;
    logic scl_low; logic sda_low; logic sck_o;
    logic prev_scl; logic prev_sda; logic prev_sck; logic [3:0] scnt; logic addr_byte; logic evt;
  } spc_state_s;
endpackage

/* File: testbench/spc_spi_peer.sv */
// spi peer model: answers as a slave, drives frames as a master
`timescale 1ns/100ps
module spc_spi_peer (
  input wire logic i_clk,
  input wire logic i_sck,
  input wire logic i_sdo,
  output logic o_sck,
  output logic o_sdi
);
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic sck_q;
  initial begin
    tx_byte = 8'h00;
    rx_byte = 8'h00;
    sck_q = 1'b0;
    o_sck = 1'b0;
    o_sdi = 1'b0;
  end
  // ==========
  // slave role: new bit on the active edge, capture on the idle edge
  // rotating the inverse in keeps the line moving outside frames
  always @(posedge i_clk) begin
    sck_q <= i_sck;
    if (i_sck && !sck_q) begin
      o_sdi <= tx_byte[7];
      tx_byte <= {tx_byte[6:0], ~tx_byte[7]};
    end
    if (!i_sck && sck_q) begin
      rx_byte <= {rx_byte[6:0], i_sdo};
    end
  end
  // master role: clock stands low between frames; data moves on the leading
  // edge so it still stands when the slave samples the trailing edge late
  task automatic send(input logic [7:0] b, input int half);
    for (int i = 7; i >= 0; i--) begin
      o_sck <= 1'b1;
      o_sdi <= b[i];
      repeat (half) @(posedge i_clk);
      o_sck <= 1'b0;
      repeat (half) @(posedge i_clk);
    end
    o_sdi <= ~b[0];
    repeat (4) @(posedge i_clk);
  endtask
endmodule

/* File: testbench/spc_ctrl_tb.sv */
// self-checking bench of the serial port control block
`timescale 1ns/100ps
`include "spc_cfg.svh"
module spc_ctrl_tb;
  logic clk, rst_n, psel, penable, pwrite, sel_n, pl_scl, pl_sda, pready, pslverr, tmr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic sck, sck_oe, sdo, sdo_oe, scl_oe, sda_oe, spi_own, sel_own, i2c_own, evt, p_sck, p_sdi, err;
  int mismatches, n_checks, hi_cnt, evt_cnt;
  logic [3:0] modes[5] = '{4'h0, 4'h1, 4'h2, 4'ha, 4'h3};
  // timer mode: match held high gives one half period per cycle
  int his[5] = '{16, 64, 256, 32, 8};
  logic [2:0] own;
  wire scl = ~(scl_oe | pl_scl);
  wire sda = ~(sda_oe | pl_sda);
  spc_ctrl spc_ctrl_inst (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_timer_two_period_match(tmr), .i_spi_clock_pin(p_sck),
    .i_spi_data_in_pin(p_sdi), .i_spi_select_pin_n(sel_n), .i_scl_in(scl), .i_sda_in(sda),
    .o_spi_clock_pin(sck), .o_spi_clock_oe(sck_oe), .o_spi_data_out_pin(sdo),
    .o_spi_data_out_oe(sdo_oe), .o_scl_out(), .o_scl_oe(scl_oe), .o_sda_out(), .o_sda_oe(sda_oe),
    .o_spi_pins_owned(spi_own), .o_select_pin_owned(sel_own), .o_i2c_pins_owned(i2c_own),
    .o_port_event(evt));
  spc_spi_peer spc_spi_peer_inst (.i_clk(clk), .i_sck(sck), .i_sdo(sdo), .o_sck(p_sck), .o_sdi(p_sdi));
  // ==========
  // clock and event counters
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (sck === 1'b1) hi_cnt++;
    if (evt === 1'b1) evt_cnt++;
  end
  // ==========
  // verdict and checks
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // ==========
  // apb master: setup, then access held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      mismatches++;
      summarize();
    end
    // let an edge pass so a following call never re-drives psel in this step
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(q, exp, what);
  endtask
  // bounded poll until the masked bits read zero
  task automatic wait_clr(input logic [7:0] a, input logic [31:0] m);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h0);
      k++;
    end while ((q & m) !== 32'h0 && k < 400);
    if (k >= 400) begin
      mismatches++;
      summarize();
    end
  endtask
  // ==========
  // main sequence
  initial begin
    {rst_n, psel, penable, pwrite, pl_scl, pl_sda, sel_n, tmr} = 8'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {mismatches, n_checks, hi_cnt, evt_cnt} = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(`SPC_A_CON1, 32'h0, "con1 reset");
    rdc(`SPC_A_CON2, 32'h0, "con2 reset");
    rdc(`SPC_A_CON3, 32'h0, "con3 reset");
    apb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0, "unmapped read");
    chk({31'h0, err}, 32'h1, "unmapped error");
    $display("test reset done");
    for (int m = 0; m < 16; m++) begin
      apb(1'b1, `SPC_A_CON1, 32'h20 | m);
      @(negedge clk);
      own = {m < 6 || m == 10, m == 4, m inside {6, 7, 8, 11, 14, 15}};
      chk({spi_own, sel_own, i2c_own}, own, "pin owner");
      @(posedge clk);
    end
    apb(1'b1, `SPC_A_CON1, 32'h30);
    repeat (3) @(negedge clk);
    chk({sck, sck_oe}, 2'b11, "idle high");
    @(posedge clk);
    apb(1'b1, `SPC_A_CON1, 32'h10);
    @(negedge clk);
    chk({spi_own, sck_oe}, 2'b00, "disabled");
    @(posedge clk);
    $display("test pins done");
    apb(1'b1, `SPC_A_DIV, 32'h1);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `SPC_A_CON1, 32'h20 | modes[i]);
      tmr <= (i == 4);
      spc_spi_peer_inst.tx_byte = 8'h3c;
      hi_cnt = 0;
      apb(1'b1, `SPC_A_BUF, 32'ha5);
      if (i == 0) apb(1'b1, `SPC_A_BUF, 32'h11);
      wait_clr(`SPC_A_STAT, 32'h2);
      chk(hi_cnt, his[i], "spi rate");
      rdc(`SPC_A_CON1, {i == 0, 3'b010, modes[i]}, "master flags");
      rdc(`SPC_A_STAT, 32'h1, "full");
      rdc(`SPC_A_BUF, 32'h3c, "spi rx");
      chk(spc_spi_peer_inst.rx_byte, 8'ha5, "spi tx");
      rdc(`SPC_A_STAT, 32'h0, "empty");
    end
    $display("test spi master done");
    apb(1'b1, `SPC_A_CON1, 32'h25);
    spc_spi_peer_inst.send(8'h81, 3);
    spc_spi_peer_inst.send(8'h7e, 3);
    rdc(`SPC_A_CON1, 32'h65, "overflow");
    rdc(`SPC_A_BUF, 32'h81, "kept");
    apb(1'b1, `SPC_A_CON1, 32'h25);
    apb(1'b1, `SPC_A_CON3, 32'h10);
    spc_spi_peer_inst.send(8'h24, 3);
    spc_spi_peer_inst.send(8'h42, 3);
    rdc(`SPC_A_BUF, 32'h42, "overwrite");
    apb(1'b1, `SPC_A_CON1, 32'h25);
    fork
      spc_spi_peer_inst.send(8'h0f, 3);
      begin
        repeat (20) @(posedge clk);
        apb(1'b1, `SPC_A_BUF, 32'h55);
      end
    join
    rdc(`SPC_A_CON1, 32'ha5, "slave collision");
    $display("test spi slave done");
    apb(1'b1, `SPC_A_DIV, 32'h3);
    apb(1'b1, `SPC_A_CON1, 32'h28);
    apb(1'b1, `SPC_A_CON2, 32'h1);
    apb(1'b1, `SPC_A_CON2, 32'h4);
    rdc(`SPC_A_CON2, 32'h1, "busy ignores");
    wait_clr(`SPC_A_CON2, 32'h1f);
    apb(1'b1, `SPC_A_BUF, 32'h5a);
    wait_clr(`SPC_A_STAT, 32'h2);
    rdc(`SPC_A_CON2, 32'h40, "no ack");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `SPC_A_CON2, i == 0 ? 32'h8 : i == 1 ? 32'h30 : i == 2 ? 32'h10 : i == 3 ? 32'h2 : 32'h4);
      wait_clr(`SPC_A_CON2, 32'h1f);
      if (i == 0) rdc(`SPC_A_BUF, 32'hff, "i2c rx");
    end
    $display("test i2c master done");
    apb(1'b1, `SPC_A_CON1, 32'h26);
    chk({31'h0, scl_oe}, 32'h1, "slave hold");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `SPC_A_CON3, i == 1 ? 32'h60 : 32'h0);
      apb(1'b1, `SPC_A_CON1, i == 2 ? 32'h3e : 32'h36);
      evt_cnt = 0;
      pl_sda <= 1'b1;
      repeat (10) @(posedge clk);
      pl_sda <= 1'b0;
      repeat (10) @(posedge clk);
      chk(evt_cnt, i == 0 ? 0 : 2, "start stop events");
    end
    $display("test i2c slave done");
    summarize();
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule
